/* inc/pmx_pkg.sv */
// package for the processor-mode and bus configuration block
// assumes a 125 MHz bus clock and an 8-bit register file behind classic Wishbone
package pmx_pkg;

  // register indices (byte address is four times the index)
  localparam logic [9:0] IDX_PROC_MODE_ZERO   = 10'h004;
  localparam logic [9:0] IDX_PROC_MODE_ONE    = 10'h005;
  localparam logic [9:0] IDX_CHIP_SEL_CTRL    = 10'h008;
  localparam logic [9:0] IDX_EXT_RECOVERY     = 10'h009;
  localparam logic [9:0] IDX_PROGRAM2_AREA    = 10'h010;
  localparam logic [9:0] IDX_EXT_WAIT_EXP     = 10'h011;
  localparam logic [9:0] IDX_CS_WAIT_EXP      = 10'h01B;
  localparam logic [9:0] IDX_PROC_MODE_TWO    = 10'h01E;
  localparam logic [9:0] IDX_WRITE_PROTECT    = 10'h00A;
  localparam logic [9:0] IDX_FLASH_CTRL_ONE   = 10'h221;
  localparam logic [9:0] IDX_BUS_STATUS       = 10'h040;

  // reset values
  localparam logic [7:0] RST_PROC_MODE_ONE    = 8'h08;
  localparam logic [7:0] RST_CHIP_SEL_CTRL    = 8'h01;
  localparam logic [7:0] RST_EXT_RECOVERY     = 8'h00;
  localparam logic [7:0] RST_EXT_WAIT_EXP     = 8'h00;
  localparam logic [7:0] RST_CS_WAIT_EXP      = 8'h00;
  localparam logic [7:0] RST_PROC_MODE_TWO    = 8'h01;
  localparam logic [7:0] RST_FLASH_CTRL_ONE   = 8'h00;
  localparam logic [7:0] RST_PROGRAM2_AREA    = 8'h00;

  // field positions
  localparam int BIT_UPPER_WINDOW   = 1;   // in program2 area control
  localparam int BIT_EXPAND0        = 3;   // in processor mode one
  localparam int BIT_SPACE_LO       = 4;
  localparam int BIT_SPACE_HI       = 5;
  localparam int BIT_GLOBAL_WAIT    = 7;
  localparam int BIT_AREA_UNLOCK    = 6;   // in write protect
  localparam int BIT_MODE_UNLOCK    = 1;
  localparam int BIT_WDT_PROTECT    = 0;   // in processor mode two (own placement)
  localparam int BIT_EW1            = 1;   // in flash control one
  localparam int BIT_AUTO_BUSY      = 7;

  // processor modes
  typedef enum logic [1:0] {
    MODE_SINGLE   = 2'b00,
    MODE_EXPAND   = 2'b01,
    MODE_RESERVED = 2'b10,
    MODE_MICRO    = 2'b11
  } proc_mode_e;

  // 512 kbyte boundary for program rom 1 upper window
  localparam int ROM1_WINDOW_KBYTES = 512;
  localparam logic [19:0] WIN_LO = 20'h40000;
  localparam logic [19:0] WIN_HI = 20'h7FFFF;

  // decoded region for a bus address
  typedef enum logic [1:0] {
    AREA_INTERNAL = 2'b00,
    AREA_EXTERNAL = 2'b01,
    AREA_RESERVED = 2'b10
  } area_e;

  // bus access request from the cpu/dma side
  typedef struct packed {
    logic        valid;
    logic [19:0] addr;
    logic        word;
    logic [1:0]  cs;
    logic        internal;
  } bus_req_s;

  // timing applied to one bus cycle
  typedef struct packed {
    logic [3:0] setup;
    logic [3:0] strobe;
    logic [1:0] recovery;
  } cyc_timing_s;

  // 2-stage synchroniser depth
  localparam int SYNC_STAGES = 2;
  localparam logic [3:0] MAX_EXT_WAITS = 4'h8;

endpackage : pmx_pkg

/* rtl/pmx_cycle_timer.sv */
// bus cycle timer: stretches one access by setup, strobe and recovery counts
// assumes a start pulse only while idle; counts in bus clock cycles
`timescale 1ns/1ps
`default_nettype none
module pmx_cycle_timer (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_start,
  input  wire pmx_pkg::cyc_timing_s i_timing,
  output var  logic                 o_busy,
  output var  logic                 o_strobe,
  output var  logic                 o_done
);
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETUP  = 2'b01,
    ST_STROBE = 2'b10,
    ST_RECOV  = 2'b11
  } tstate_e;

  tstate_e    state_ff;
  logic [3:0] cnt_ff;
  logic [1:0] rec_ff;
  logic [3:0] strobe_len_ff;

  // one access: setup then strobe then optional recovery
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_ff      <= ST_IDLE;
      cnt_ff        <= 4'h0;
      rec_ff        <= 2'h0;
      strobe_len_ff <= 4'h0;
      o_done        <= 1'b0;
    end else begin
      o_done <= 1'b0;
      unique case (state_ff)
        ST_IDLE: begin
          if (i_start) begin
            state_ff      <= ST_SETUP;
            cnt_ff        <= i_timing.setup;
            rec_ff        <= i_timing.recovery;
            strobe_len_ff <= i_timing.strobe;
          end
        end
        ST_SETUP: begin
          if (cnt_ff <= 4'h1) begin
            state_ff <= ST_STROBE;
            cnt_ff   <= strobe_len_ff;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        ST_STROBE: begin
          if (cnt_ff <= 4'h1) begin
            if (rec_ff == 2'h0) begin
              state_ff <= ST_IDLE;
              o_done   <= 1'b1;
            end else begin
              state_ff <= ST_RECOV;
              cnt_ff   <= {2'h0, rec_ff};
            end
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        ST_RECOV: begin
          if (cnt_ff <= 4'h1) begin
            state_ff <= ST_IDLE;
            o_done   <= 1'b1;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
      endcase
    end
  end

  assign o_busy   = (state_ff != ST_IDLE);
  assign o_strobe = (state_ff == ST_STROBE);
endmodule : pmx_cycle_timer
`default_nettype wire

/* rtl/pmx_mode_bus_ctrl.sv */
// processor-mode selection, area decode, wait timing and bus arbitration
// assumes classic wishbone registers on I_CLOCK; pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
module pmx_mode_bus_ctrl #(
  parameter bit ROM1_LARGE = 1'b1
) (
  input  wire logic                I_CLOCK,
  input  wire logic                I_RST_N,
  input  wire logic                I_HARD_RESET,
  input  wire logic                I_BOOT_MODE_PIN,
  input  wire logic                I_HOLD_REQ_N,
  input  wire logic                I_FLASH_AUTO_BUSY,
  input  wire logic                I_MUX_BUS,
  input  wire logic                I_BYTE_WIDE,
  input  wire logic                I_BUS_CLK_LINK,
  input  wire pmx_pkg::bus_req_s   I_CPU_REQ,
  input  wire pmx_pkg::bus_req_s   I_DMA_REQ,
  input  wire logic                I_CPU_ODD_WORD,
  input  wire logic                I_CYC_I,
  input  wire logic                I_STB_I,
  input  wire logic                I_WE_I,
  input  wire logic [11:0]         I_ADR_I,
  input  wire logic [3:0]          I_SEL_I,
  input  wire logic [31:0]         I_DAT_I,
  output var  logic [31:0]         O_DAT_O,
  output var  logic                O_ACK_O,
  output var  logic [1:0]          O_PROC_MODE,
  output var  logic                O_ROM_BLOCKED,
  output var  logic [1:0]          O_AREA,
  output var  logic                O_BUS_HOLD_ACK,
  output var  logic                O_CPU_STOP,
  output var  logic                O_DMA_STOP,
  output var  logic                O_WDT_STOP,
  output var  logic                O_CPU_GNT,
  output var  logic                O_DMA_GNT,
  output var  logic                O_EXT_STROBE,
  output var  logic                O_CYCLE_DONE,
  output var  logic                O_STROBE_SPLIT
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic hold_n_s;
  logic busy_s;
  logic boot_s;
  logic link_s;

  pmx_sync #(.WIDTH(4)) u_sync (
    .i_clk   (I_CLOCK),
    .i_rst_n (I_RST_N),
    .i_async ({I_HOLD_REQ_N, I_FLASH_AUTO_BUSY, I_BOOT_MODE_PIN, I_BUS_CLK_LINK}),
    .o_sync  ({hold_n_s, busy_s, boot_s, link_s})
  );

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] pm0_ff;        // processor_mode_zero: mode field low two bits
  logic [7:0] pm1_ff;
  logic [7:0] csr_ff;
  logic [7:0] ewr_ff;
  logic [7:0] ewc_ff;
  logic [7:0] cse_ff;
  logic [7:0] pm2_ff;
  logic [7:0] flash_control_one_ff;
  logic [7:0] prg2_ff;
  logic [7:0] prot_ff;
  logic       rom_block_ff;
  logic       ack_ff;

  logic       wb_req;
  logic       wb_wr;
  logic [9:0] idx;

  // word-aligned index; one access answered one cycle after it is taken
  assign wb_req = I_CYC_I && I_STB_I && !ack_ff;
  assign wb_wr  = wb_req && I_WE_I && I_SEL_I[0];
  assign idx    = I_ADR_I[11:2];

  // reserved code refused so mode never leaves a defined state
  function automatic logic [1:0] next_mode(input logic [1:0] cur, input logic [1:0] req);
    next_mode = (req == pmx_pkg::MODE_RESERVED) ? cur : req;
  endfunction : next_mode

  // rom block changes only on I_RST_N and pin-sampling hard resets; mode field also on writes while mode unlock is set
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      pm0_ff       <= 8'h00;
      rom_block_ff <= 1'b0;
    end else if (I_HARD_RESET) begin
      pm0_ff       <= boot_s ? {6'h00, pmx_pkg::MODE_MICRO} : 8'h00;
      rom_block_ff <= boot_s;
    end else if (wb_wr && idx == pmx_pkg::IDX_PROC_MODE_ZERO
                 && prot_ff[pmx_pkg::BIT_MODE_UNLOCK]) begin
      pm0_ff <= {I_DAT_I[7:2], next_mode(pm0_ff[1:0], I_DAT_I[1:0])};
    end
  end

  // write protect unlock bits, plain read/write
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      prot_ff <= 8'h00;
    end else if (wb_wr && idx == pmx_pkg::IDX_WRITE_PROTECT) begin
      prot_ff <= I_DAT_I[7:0];
    end
  end

  // upper window enable gated by area unlock
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      prg2_ff <= pmx_pkg::RST_PROGRAM2_AREA;
    end else if (wb_wr && idx == pmx_pkg::IDX_PROGRAM2_AREA
                 && prot_ff[pmx_pkg::BIT_AREA_UNLOCK]) begin
      prg2_ff <= {6'h00, I_DAT_I[1:0]};
    end
  end

  // configuration registers of the bus
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      pm1_ff  <= pmx_pkg::RST_PROC_MODE_ONE;
      csr_ff  <= pmx_pkg::RST_CHIP_SEL_CTRL;
      ewr_ff  <= pmx_pkg::RST_EXT_RECOVERY;
      ewc_ff  <= pmx_pkg::RST_EXT_WAIT_EXP;
      cse_ff  <= pmx_pkg::RST_CS_WAIT_EXP;
      pm2_ff  <= pmx_pkg::RST_PROC_MODE_TWO;
      flash_control_one_ff <= pmx_pkg::RST_FLASH_CTRL_ONE;
    end else if (wb_wr) begin
      unique case (idx)
        pmx_pkg::IDX_PROC_MODE_ONE:  pm1_ff  <= I_DAT_I[7:0];
        pmx_pkg::IDX_CHIP_SEL_CTRL:  csr_ff  <= I_DAT_I[7:0];
        pmx_pkg::IDX_EXT_RECOVERY:   ewr_ff  <= {6'h00, I_DAT_I[1:0]};
        pmx_pkg::IDX_EXT_WAIT_EXP:   ewc_ff  <= I_DAT_I[7:0];
        pmx_pkg::IDX_CS_WAIT_EXP:    cse_ff  <= I_DAT_I[7:0];
        pmx_pkg::IDX_PROC_MODE_TWO:  pm2_ff  <= I_DAT_I[7:0];
        pmx_pkg::IDX_FLASH_CTRL_ONE: flash_control_one_ff <= {1'b0, I_DAT_I[6:0]};
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address decode of the upper rom 1 window

  logic [1:0] mode;
  logic       in_window;
  logic       win_en;
  logic       ext_mode;
  pmx_pkg::area_e area;

  assign mode      = pm0_ff[1:0];
  assign ext_mode  = (mode == pmx_pkg::MODE_EXPAND) || (mode == pmx_pkg::MODE_MICRO);
  assign win_en    = prg2_ff[pmx_pkg::BIT_UPPER_WINDOW];

  // window check, applied to the cpu request address only
  function automatic logic in_win(input logic [19:0] a);
    in_win = (a >= pmx_pkg::WIN_LO) && (a <= pmx_pkg::WIN_HI);
  endfunction : in_win

  assign in_window = in_win(I_CPU_REQ.addr);

  // region class of the current cpu address
  always_comb begin
    area = pmx_pkg::AREA_INTERNAL;
    if (in_window) begin
      if (mode == pmx_pkg::MODE_MICRO) begin
        area = pmx_pkg::AREA_EXTERNAL;
      end else if (!win_en) begin
        area = (mode == pmx_pkg::MODE_EXPAND) ? pmx_pkg::AREA_EXTERNAL
                                              : pmx_pkg::AREA_RESERVED;
      end else begin
        area = ROM1_LARGE ? pmx_pkg::AREA_INTERNAL : pmx_pkg::AREA_RESERVED;
      end
    end
    if (area == pmx_pkg::AREA_INTERNAL && I_CPU_REQ.internal && rom_block_ff) begin
      area = pmx_pkg::AREA_RESERVED;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // hold and arbitration

  logic hold_want;
  logic tmr_busy;
  logic tmr_done;
  logic tmr_strobe;
  logic hold_ack_ff;
  logic dma_gnt_ff;
  logic cpu_gnt_ff;
  logic odd_lock_ff;

  // ew1 auto operation, or hold pin only outside single-chip
  assign hold_want = (flash_control_one_ff[pmx_pkg::BIT_EW1] && busy_s)
                   || (!hold_n_s && ext_mode);

  // odd-address word access holds the grants only until tmr_done ends the first cycle
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      odd_lock_ff <= 1'b0;
    end else if (cpu_gnt_ff && I_CPU_ODD_WORD && !odd_lock_ff) begin
      odd_lock_ff <= 1'b1;
    end else if (tmr_done) begin
      odd_lock_ff <= 1'b0;
    end
  end

  // fixed priority grant, taken only between cycles
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      hold_ack_ff <= 1'b0;
      dma_gnt_ff  <= 1'b0;
      cpu_gnt_ff  <= 1'b0;
    end else if (!tmr_busy && !odd_lock_ff) begin
      hold_ack_ff <= hold_want;
      dma_gnt_ff  <= !hold_want && I_DMA_REQ.valid;
      cpu_gnt_ff  <= !hold_want && !I_DMA_REQ.valid && I_CPU_REQ.valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-area timing selection

  pmx_pkg::cyc_timing_s timing;
  logic [1:0] cs;
  logic [1:0] wcnt;
  logic       start;

  assign cs   = dma_gnt_ff ? I_DMA_REQ.cs : I_CPU_REQ.cs;
  assign wcnt = cse_ff[2*cs +: 2];

  // wait count per source: internal 0..1 waits, external per chip select
  always_comb begin
    timing = '{setup: 4'h1, strobe: 4'h1, recovery: 2'h0};
    if (area != pmx_pkg::AREA_EXTERNAL || !ext_mode) begin
      timing.strobe = pm1_ff[pmx_pkg::BIT_GLOBAL_WAIT] ? 4'h2 : 4'h1;
    end else if (csr_ff[4 + cs]) begin
      timing.strobe = 4'h1;
    end else if (wcnt != 2'b11) begin
      timing.strobe = 4'h1 + {2'h0, wcnt} + 4'h1;
    end else begin
      timing.setup    = {2'h0, ewc_ff[2*cs +: 2]} + 4'h1;
      timing.strobe   = pmx_pkg::MAX_EXT_WAITS - 4'h5 + {3'h0, ewc_ff[2*cs+1]};
      timing.recovery = ewr_ff[1:0];
    end
  end

  // no fresh cycle while hold is wanted unless odd_lock_ff is set, so the acknowledge never overlaps a new access
  assign start = (cpu_gnt_ff || dma_gnt_ff) && !tmr_busy && !tmr_done
               && (odd_lock_ff || !hold_want);

  pmx_cycle_timer u_timer (
    .i_clk    (I_CLOCK),
    .i_rst_n  (I_RST_N),
    .i_start  (start),
    .i_timing (timing),
    .o_busy   (tmr_busy),
    .o_strobe (tmr_strobe),
    .o_done   (tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // wishbone read path and answer

  logic [7:0] rd;

  // status word: hold, grants, blocked rom, synced link clock level
  always_comb begin
    unique case (idx)
      pmx_pkg::IDX_PROC_MODE_ZERO: rd = pm0_ff;
      pmx_pkg::IDX_PROC_MODE_ONE:  rd = pm1_ff;
      pmx_pkg::IDX_CHIP_SEL_CTRL:  rd = csr_ff;
      pmx_pkg::IDX_EXT_RECOVERY:   rd = ewr_ff;
      pmx_pkg::IDX_PROGRAM2_AREA:  rd = prg2_ff;
      pmx_pkg::IDX_WRITE_PROTECT:  rd = prot_ff;
      pmx_pkg::IDX_EXT_WAIT_EXP:   rd = ewc_ff;
      pmx_pkg::IDX_CS_WAIT_EXP:    rd = cse_ff;
      pmx_pkg::IDX_PROC_MODE_TWO:  rd = pm2_ff;
      pmx_pkg::IDX_FLASH_CTRL_ONE: rd = {busy_s, flash_control_one_ff[6:0]};
      pmx_pkg::IDX_BUS_STATUS:     rd = {link_s, rom_block_ff, tmr_busy, cpu_gnt_ff,
                                         dma_gnt_ff, hold_ack_ff, mode};
      default:                     rd = 8'h00;
    endcase
  end

  // unmapped addresses read zero and ignore writes, still acknowledged
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      ack_ff  <= 1'b0;
      O_DAT_O <= 32'h0000_0000;
    end else begin
      ack_ff  <= wb_req;
      O_DAT_O <= wb_req ? {24'h00_0000, rd} : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs

  // hold stops cpu and dma; watchdog only without source protection
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      O_PROC_MODE    <= 2'b00;
      O_ROM_BLOCKED  <= 1'b0;
      O_AREA         <= 2'b00;
      O_BUS_HOLD_ACK <= 1'b0;
      O_CPU_STOP     <= 1'b0;
      O_DMA_STOP     <= 1'b0;
      O_WDT_STOP     <= 1'b0;
      O_CPU_GNT      <= 1'b0;
      O_DMA_GNT      <= 1'b0;
      O_EXT_STROBE   <= 1'b0;
      O_CYCLE_DONE   <= 1'b0;
      O_STROBE_SPLIT <= 1'b0;
    end else begin
      O_PROC_MODE    <= mode;
      O_ROM_BLOCKED  <= rom_block_ff;
      O_AREA         <= area;
      O_BUS_HOLD_ACK <= hold_ack_ff;
      O_CPU_STOP     <= hold_ack_ff;
      O_DMA_STOP     <= hold_ack_ff;
      O_WDT_STOP     <= hold_ack_ff && !pm2_ff[pmx_pkg::BIT_WDT_PROTECT];
      O_CPU_GNT      <= cpu_gnt_ff;
      O_DMA_GNT      <= dma_gnt_ff;
      O_EXT_STROBE   <= tmr_strobe && ext_mode;
      O_CYCLE_DONE   <= tmr_done;
      O_STROBE_SPLIT <= pm0_ff[2] && !I_BYTE_WIDE && !I_MUX_BUS;
    end
  end

  assign O_ACK_O = ack_ff;

endmodule : pmx_mode_bus_ctrl
`default_nettype wire

/* rtl/pmx_sync.sv */
// two-flop synchroniser for pins from outside the bus clock domain
// assumes asynchronous inputs; the first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module pmx_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output var  logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_ff;

  // two flops, meta stage read by nothing else
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_ff <= '0;
      o_sync  <= '0;
    end else begin
      meta_ff <= i_async;
      o_sync  <= meta_ff;
    end
  end
endmodule : pmx_sync
`default_nettype wire

/* verification/pmx_ext_peer.sv */
// peer model: external bus master asking for hold, and the link clock
// assumes the bench commands hold; the link clock runs free at 160 ns
`timescale 1ns/1ps
`default_nettype none
module pmx_ext_peer (
  input  wire logic i_clk,
  input  wire logic i_hold_want,
  output var  logic o_hold_req_n,
  output var  logic o_link_clk
);
  // hold pin moves just after an edge, like a synchronous master would
  always @(posedge i_clk) o_hold_req_n <= !i_hold_want;
  // odd phase offset so the link never lines up with the bus clock
  initial begin
    o_link_clk = 1'b0;
    #3;
    forever #80 o_link_clk = !o_link_clk;
  end
endmodule : pmx_ext_peer
`default_nettype wire

/* verification/pmx_mode_checker.sv */
// checker: port relations of the mode and bus control block
// assumes it is bound to pmx_mode_bus_ctrl and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module pmx_mode_checker (
  input wire logic       I_CLOCK,
  input wire logic       I_RST_N,
  input wire logic       I_HOLD_REQ_N,
  input wire logic       I_FLASH_AUTO_BUSY,
  input wire logic       I_CYC_I,
  input wire logic       I_STB_I,
  input wire logic       O_ACK_O,
  input wire logic [1:0] O_PROC_MODE,
  input wire logic       O_BUS_HOLD_ACK,
  input wire logic       O_CPU_STOP,
  input wire logic       O_DMA_STOP,
  input wire logic       O_WDT_STOP,
  input wire logic       O_CPU_GNT,
  input wire logic       O_DMA_GNT,
  input wire logic       O_EXT_STROBE,
  input wire logic       O_CYCLE_DONE
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);
  logic [5:0] hold_cnt_ff;
  ////////////////////////////////////////
  // hold wanted outside single-chip; 40 cycles covers the longest bus cycle
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N || I_HOLD_REQ_N || O_PROC_MODE == 2'h0) hold_cnt_ff <= 6'h00;
    else if (hold_cnt_ff != 6'h3F) hold_cnt_ff <= hold_cnt_ff + 6'h01;
  end
  ////////////////////////////////////////
  AST_ACK_NEXT: assert property (I_CYC_I && I_STB_I && !O_ACK_O |=> O_ACK_O)
    else $error("register ack late");
  AST_ACK_PULSE: assert property (O_ACK_O |=> !O_ACK_O)
    else $error("register ack too long");
  AST_NO_RESERVED: assert property (O_PROC_MODE != 2'h2)
    else $error("reserved mode entered");
  AST_HOLD_STOPS: assert property (O_BUS_HOLD_ACK |-> O_CPU_STOP && O_DMA_STOP)
    else $error("hold without cpu and dma stop");
  AST_WDT_IN_HOLD: assert property (O_WDT_STOP |-> O_BUS_HOLD_ACK)
    else $error("watchdog stopped outside hold");
  AST_HOLD_NO_GNT: assert property (O_BUS_HOLD_ACK |-> !O_CPU_GNT && !O_DMA_GNT)
    else $error("grant during hold");
  AST_ONE_GNT: assert property (!(O_CPU_GNT && O_DMA_GNT))
    else $error("cpu and dma granted together");
  AST_NO_CAUSE: assert property ((I_HOLD_REQ_N && !I_FLASH_AUTO_BUSY)[*6] |-> !O_BUS_HOLD_ACK)
    else $error("hold ack without cause");
  AST_HOLD_BOUND: assert property (hold_cnt_ff == 6'h28 |-> O_BUS_HOLD_ACK)
    else $error("hold ack missing");
  AST_STROBE_EXT: assert property (O_EXT_STROBE |-> O_PROC_MODE != 2'h0)
    else $error("external strobe in single-chip mode");
  AST_HOLD_QUIET: assert property (O_BUS_HOLD_ACK |-> !O_EXT_STROBE)
    else $error("external strobe during hold");
  AST_DONE_PULSE: assert property (O_CYCLE_DONE |=> !O_CYCLE_DONE)
    else $error("cycle done too long");
  COV_ACK: cover property (O_ACK_O);
  COV_HOLD: cover property ($rose(O_BUS_HOLD_ACK));
  COV_MICRO: cover property (O_PROC_MODE == 2'h3);
endmodule : pmx_mode_checker

bind pmx_mode_bus_ctrl pmx_mode_checker u_chk (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N),
  .I_HOLD_REQ_N(I_HOLD_REQ_N), .I_FLASH_AUTO_BUSY(I_FLASH_AUTO_BUSY), .I_CYC_I(I_CYC_I),
  .I_STB_I(I_STB_I), .O_ACK_O(O_ACK_O), .O_PROC_MODE(O_PROC_MODE),
  .O_BUS_HOLD_ACK(O_BUS_HOLD_ACK), .O_CPU_STOP(O_CPU_STOP), .O_DMA_STOP(O_DMA_STOP),
  .O_WDT_STOP(O_WDT_STOP), .O_CPU_GNT(O_CPU_GNT), .O_DMA_GNT(O_DMA_GNT),
  .O_EXT_STROBE(O_EXT_STROBE), .O_CYCLE_DONE(O_CYCLE_DONE));
`default_nettype wire

/* verification/tb_top.sv */
// bench: register, mode, window and hold sequences over wishbone
// assumes the bound checker and the peer model beside the design
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, hard = 1'b0, pin = 1'b0, fb = 1'b0, hw = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, hold_n, link, ack, hack, cs, ds, cg, rb;
  logic [11:0] adr = 12'h000;
  logic [31:0] dat = 32'h0, rdat;
  logic [7:0]  q;
  logic [1:0]  mode, ar;
  logic        wd, dg, sp;
  pmx_pkg::bus_req_s cpu = '0, dma = '0;
  int bad_count = 0, check_count = 0;
  logic [11:0] ra [6] = '{12'h014, 12'h020, 12'h024, 12'h044, 12'h06C, 12'hFFC};
  logic [7:0]  rv [6] = '{8'h08, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [1:0]  mc [4] = '{2'h1, 2'h0, 2'h3, 2'h2};
  logic [1:0]  em [4] = '{2'h1, 2'h0, 2'h3, 2'h3};
  pmx_mode_bus_ctrl DUT (.I_CLOCK(clk), .I_RST_N(rst_n), .I_HARD_RESET(hard),
    .I_BOOT_MODE_PIN(pin), .I_HOLD_REQ_N(hold_n), .I_FLASH_AUTO_BUSY(fb), .I_MUX_BUS(1'b0),
    .I_BYTE_WIDE(1'b0), .I_BUS_CLK_LINK(link), .I_CPU_REQ(cpu), .I_DMA_REQ(dma),
    .I_CPU_ODD_WORD(1'b0), .I_CYC_I(cyc), .I_STB_I(stb), .I_WE_I(we), .I_ADR_I(adr),
    .I_SEL_I(4'h1), .I_DAT_I(dat), .O_DAT_O(rdat), .O_ACK_O(ack), .O_PROC_MODE(mode),
    .O_ROM_BLOCKED(rb), .O_AREA(ar), .O_BUS_HOLD_ACK(hack), .O_CPU_STOP(cs), .O_DMA_STOP(ds),
    .O_WDT_STOP(wd), .O_CPU_GNT(cg), .O_DMA_GNT(dg), .O_EXT_STROBE(), .O_CYCLE_DONE(),
    .O_STROBE_SPLIT(sp));
  pmx_ext_peer PEER (.i_clk(clk), .i_hold_want(hw), .o_hold_req_n(hold_n), .o_link_clk(link));
  always #4 clk = !clk;
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  // one classic cycle; the request holds until ack is sampled high
  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h000000, d};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 16);
    q = rdat[7:0];
    if (ack !== 1'b1) chk("ack timeout", 8'h00, 8'h01);
    if (ack !== 1'b1) close_out();
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  // bounded wait on the hold acknowledge reaching a level
  task automatic wait_hold(input logic v);
    for (int k = 0; k < 60 && hack !== v; k++) @(posedge clk);
    chk("hold ack", {7'h00, hack}, {7'h00, v});
    if (hack !== v) close_out();
  endtask : wait_hold
  // pin settles through its synchroniser before the reset event samples it
  task automatic hard_rst(input logic p);
    pin <= p;
    repeat (3) @(posedge clk);
    hard <= 1'b1;
    repeat (3) @(posedge clk);
    hard <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : hard_rst
  ////////////////////////////////////////
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    hard_rst(1'b0);
    chk("mode pin low", {6'h00, mode}, 8'h00);
    chk("rom open", {7'h00, rb}, 8'h00);
    foreach (ra[i]) begin
      wb(1'b0, ra[i], 8'h00);
      chk("reset value", q, rv[i]);
    end
    wb(1'b1, 12'h06C, 8'h01);
    wb(1'b0, 12'h06C, 8'h00);
    chk("wait count", q, 8'h01);
    wb(1'b1, 12'h06C, 8'h00);
    wb(1'b1, 12'h020, 8'h11);
    wb(1'b0, 12'h020, 8'h00);
    chk("no wait", q, 8'h11);
    $display("test reset done");
    wb(1'b1, 12'h040, 8'h02);
    wb(1'b0, 12'h040, 8'h00);
    chk("window locked", q & 8'h02, 8'h00);
    wb(1'b1, 12'h028, 8'h42);
    wb(1'b1, 12'h040, 8'h02);
    wb(1'b0, 12'h040, 8'h00);
    chk("window open", q & 8'h02, 8'h02);
    foreach (mc[i]) begin
      wb(1'b1, 12'h010, {6'h00, mc[i]});
      chk("mode code", {6'h00, mode}, {6'h00, em[i]});
    end
    cpu <= {1'b1, 20'h40000, 1'b0, 2'h0, 1'b1};
    repeat (2) @(posedge clk);
    chk("micro window", {6'h00, ar}, 8'h01);
    wb(1'b1, 12'h010, 8'h05);
    chk("rom1 window", {6'h00, ar}, 8'h00);
    chk("split write", {7'h00, sp}, 8'h01);
    wb(1'b1, 12'h040, 8'h00);
    chk("expansion window", {6'h00, ar}, 8'h01);
    $display("test modes done");
    wb(1'b1, 12'h078, 8'h00);
    cpu <= {1'b1, 20'h00100, 1'b0, 2'h0, 1'b1};
    hw <= 1'b1;
    wait_hold(1'b1);
    chk("stops", {5'h00, cs, ds, wd}, 8'h07);
    chk("cpu grant", {7'h00, cg}, 8'h00);
    repeat (45) @(posedge clk);
    hw <= 1'b0;
    wait_hold(1'b0);
    wb(1'b1, 12'h010, 8'h00);
    hw <= 1'b1;
    repeat (20) @(posedge clk);
    chk("single hold", {7'h00, hack}, 8'h00);
    hw <= 1'b0;
    wb(1'b1, 12'h884, 8'h02);
    wb(1'b1, 12'h078, 8'h01);
    fb <= 1'b1;
    wait_hold(1'b1);
    chk("wdt kept", {7'h00, wd}, 8'h00);
    fb <= 1'b0;
    wait_hold(1'b0);
    dma <= {1'b1, 20'h00200, 1'b0, 2'h1, 1'b1};
    repeat (20) @(posedge clk);
    chk("dma first", {6'h00, dg, cg}, 8'h02);
    dma <= '0;
    $display("test hold done");
    hard_rst(1'b1);
    chk("mode pin high", {6'h00, mode}, 8'h03);
    wb(1'b1, 12'h010, 8'h01);
    chk("rom blocked", {7'h00, rb}, 8'h01);
    chk("blocked area", {6'h00, ar}, 8'h02);
    $display("test pin done");
    close_out();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end
endmodule : tb_top
`default_nettype wire
